/* common/eiep_pkg.sv */
// eiep_pkg: constants and carrier types of the extended interrupt enable/priority block
package eiep_pkg;

	// ****************************************************************
	// special-function addresses and pages
	// ****************************************************************
	localparam logic [7:0] EIEP_ADDR_MASK_TWO = 8'he7; // second extended enable
	localparam logic [7:0] EIEP_ADDR_PRIO_ONE = 8'hf6; // first extended priority
	localparam logic [7:0] EIEP_ADDR_PRIO_TWO = 8'hf7; // second extended priority
	localparam logic [7:0] EIEP_PAGE_BASE     = 8'h00;
	localparam logic [7:0] EIEP_PAGE_CONFIG   = 8'h0f;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int EIEP_BIT_LIN      = 7;
	localparam int EIEP_BIT_TIMER3   = 6;
	localparam int EIEP_BIT_CMP1     = 5;
	localparam int EIEP_BIT_CMP0     = 4;
	localparam int EIEP_BIT_COUNTER  = 3;
	localparam int EIEP_BIT_CONVDONE = 2;
	localparam int EIEP_BIT_WINDOW   = 1;
	localparam int EIEP_BIT_SMBUS    = 0;
	localparam int EIEP_BIT_MATCH    = 2; // in both second-group registers
	localparam int EIEP_BIT_DROPOUT  = 0; // in both second-group registers

	// source index on the request vector: group one by bit, then the two others
	localparam int EIEP_SRC_MATCH    = 8;
	localparam int EIEP_SRC_DROPOUT  = 9;
	localparam int EIEP_NUM_SRC      = 10;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] EIEP_RST_PRIO_ONE = 8'h00;
	localparam logic [1:0] EIEP_RST_GROUP2   = 2'h0;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic [7:0] addr;  // special-function address
		logic [7:0] page;  // selected register page
		logic       wr;    // write strobe, one cycle
		logic       rd;    // read strobe, one cycle
		logic [7:0] wdata; // write data
	} eiep_sfr_t;

	typedef struct packed {
		logic [7:0] groupOne; // lin..smbus, index equals priority bit
		logic       match;    // port match
		logic       dropout;  // regulator dropout
	} eiep_req_t;

endpackage : eiep_pkg

/* rtl/eiep_ctrl.sv */
// eiep_ctrl: extended interrupt mask and priority registers with level resolution
`timescale 1ns/100ps

module eiep_ctrl
	import eiep_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rst_n,
	input  wire eiep_sfr_t       sfrBus,
	input  wire eiep_req_t       srcReq,
	input  wire logic [7:0]      groupOneEnable,
	input  wire logic            globalIrqEnable,
	output logic [7:0]           sfrRdata,
	output logic                 sfrAck,
	output logic                 irqHigh,
	output logic                 irqLow,
	output logic [3:0]           irqSource,
	output logic [1:0]           groupTwoEnable
);

	// ****************************************************************
	// address decode
	// ****************************************************************

	logic pageOk;
	logic selMaskTwo;
	logic selPrioOne;
	logic selPrioTwo;

	// paged registers only answer on the two listed pages
	assign pageOk     = (sfrBus.page == EIEP_PAGE_BASE) || (sfrBus.page == EIEP_PAGE_CONFIG);
	assign selMaskTwo = (sfrBus.addr == EIEP_ADDR_MASK_TWO);
	assign selPrioOne = (sfrBus.addr == EIEP_ADDR_PRIO_ONE) && pageOk;
	assign selPrioTwo = (sfrBus.addr == EIEP_ADDR_PRIO_TWO) && pageOk;

	// ****************************************************************
	// register file
	// ****************************************************************

	logic [7:0] prioOne;
	logic [1:0] maskTwo;  // {match, dropout}
	logic [1:0] prioTwo;  // {match, dropout}
	logic [7:0] next_prioOne;
	logic [1:0] next_maskTwo;
	logic [1:0] next_prioTwo;

	// writes store only implemented bits; the rest are dropped
	always_comb begin
		next_prioOne = prioOne;
		next_maskTwo = maskTwo;
		next_prioTwo = prioTwo;
		if (sfrBus.wr && selPrioOne) begin
			next_prioOne = sfrBus.wdata;
		end
		if (sfrBus.wr && selMaskTwo) begin
			next_maskTwo = {sfrBus.wdata[EIEP_BIT_MATCH], sfrBus.wdata[EIEP_BIT_DROPOUT]};
		end
		if (sfrBus.wr && selPrioTwo) begin
			next_prioTwo = {sfrBus.wdata[EIEP_BIT_MATCH], sfrBus.wdata[EIEP_BIT_DROPOUT]};
		end
	end

	// register storage, cleared at reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prioOne <= EIEP_RST_PRIO_ONE;
			maskTwo <= EIEP_RST_GROUP2;
			prioTwo <= EIEP_RST_GROUP2;
		end else begin
			prioOne <= next_prioOne;
			maskTwo <= next_maskTwo;
			prioTwo <= next_prioTwo;
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************

	logic [7:0] next_sfrRdata;
	logic       next_sfrAck;

	// read data is registered, one cycle after the strobe
	always_comb begin
		next_sfrRdata = 8'h00;
		next_sfrAck   = 1'b0;
		if (sfrBus.rd) begin
			if (selMaskTwo) begin
				next_sfrRdata = {5'h00, maskTwo[1], 1'b0, maskTwo[0]};
				next_sfrAck   = 1'b1;
			end else if (selPrioOne) begin
				next_sfrRdata = prioOne;
				next_sfrAck   = 1'b1;
			end else if (selPrioTwo) begin
				next_sfrRdata = {5'h00, prioTwo[1], 1'b0, prioTwo[0]};
				next_sfrAck   = 1'b1;
			end
		end
	end

	// read result holds until the next read strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sfrRdata <= 8'h00;
			sfrAck   <= 1'b0;
		end else begin
			sfrAck <= next_sfrAck;
			if (sfrBus.rd) begin
				sfrRdata <= next_sfrRdata;
			end
		end
	end

	assign groupTwoEnable = maskTwo;

	// ****************************************************************
	// masking and level resolution
	// ****************************************************************

	logic [EIEP_NUM_SRC-1:0] reqVec;
	logic [EIEP_NUM_SRC-1:0] enVec;
	logic [EIEP_NUM_SRC-1:0] prioVec;
	logic [EIEP_NUM_SRC-1:0] effVec;
	logic [EIEP_NUM_SRC-1:0] highVec;
	logic [EIEP_NUM_SRC-1:0] lowVec;

	assign reqVec  = {srcReq.dropout, srcReq.match, srcReq.groupOne};
	assign enVec   = {maskTwo[0], maskTwo[1], groupOneEnable};
	assign prioVec = {prioTwo[0], prioTwo[1], prioOne};
	assign effVec  = reqVec & enVec & {EIEP_NUM_SRC{globalIrqEnable}};
	assign highVec = effVec & prioVec;
	assign lowVec  = effVec & ~prioVec;

	logic       next_irqHigh;
	logic       next_irqLow;
	logic [3:0] next_irqSource;

	// high level wins; within a level the lowest index is presented
	always_comb begin
		next_irqHigh   = |highVec;
		next_irqLow    = (|lowVec) && !(|highVec);
		next_irqSource = 4'h0;
		for (int i = EIEP_NUM_SRC - 1; i >= 0; i--) begin
			if ((|highVec) ? highVec[i] : lowVec[i]) begin
				next_irqSource = 4'(i);
			end
		end
	end

	// request outputs to the core sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irqHigh   <= 1'b0;
			irqLow    <= 1'b0;
			irqSource <= 4'h0;
		end else begin
			irqHigh   <= next_irqHigh;
			irqLow    <= next_irqLow;
			irqSource <= next_irqSource;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************

	property p_group_one_high;
		@(posedge clk) disable iff (!rst_n)
		(|(reqVec[7:0] & groupOneEnable & prioOne) && globalIrqEnable) |=> irqHigh;
	endproperty
	a_group_one_high: assert property (p_group_one_high)
		else $error("group one high request not presented high");

	property p_lin_counter_level;
		@(posedge clk) disable iff (!rst_n)
		(globalIrqEnable && srcReq.groupOne == 8'h88 && groupOneEnable == 8'h88
			&& prioOne[EIEP_BIT_LIN] && prioOne[EIEP_BIT_COUNTER])
		|=> irqHigh && !irqLow && irqSource == 4'h3;
	endproperty
	a_lin_counter_level: assert property (p_lin_counter_level)
		else $error("lin or counter array priority bit not high when set");

	property p_match_blocked;
		@(posedge clk) disable iff (!rst_n)
		(!maskTwo[1] && reqVec == 10'h100) |=> !irqHigh && !irqLow;
	endproperty
	a_match_blocked: assert property (p_match_blocked)
		else $error("masked port match request passed on");

	property p_dropout_blocked;
		@(posedge clk) disable iff (!rst_n)
		(!maskTwo[0] && reqVec == 10'h200) |=> !irqHigh && !irqLow;
	endproperty
	a_dropout_blocked: assert property (p_dropout_blocked)
		else $error("masked dropout request passed on");

	property p_match_level;
		@(posedge clk) disable iff (!rst_n)
		(globalIrqEnable && maskTwo[1] && reqVec == 10'h100)
		|=> irqSource == 4'h8 && (irqHigh == $past(prioTwo[1])) && (irqLow == !$past(prioTwo[1]));
	endproperty
	a_match_level: assert property (p_match_level)
		else $error("port match level does not follow its priority bit");

	property p_dropout_level;
		@(posedge clk) disable iff (!rst_n)
		(globalIrqEnable && maskTwo[0] && reqVec == 10'h200)
		|=> irqSource == 4'h9 && (irqHigh == $past(prioTwo[0])) && (irqLow == !$past(prioTwo[0]));
	endproperty
	a_dropout_level: assert property (p_dropout_level)
		else $error("dropout level does not follow its priority bit");

	property p_reserved_zero;
		@(posedge clk) disable iff (!rst_n)
		(sfrBus.rd && (selMaskTwo || selPrioTwo))
		|=> sfrAck && sfrRdata[7:3] == 5'h00 && !sfrRdata[1];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("unused second-group bits read nonzero");

	property p_page_gate;
		@(posedge clk) disable iff (!rst_n)
		(sfrBus.rd && sfrBus.addr[7:1] == 7'h7b && !pageOk) |=> !sfrAck;
	endproperty
	a_page_gate: assert property (p_page_gate)
		else $error("paged priority register answered on a wrong page");

	property p_mask_any_page;
		@(posedge clk) disable iff (!rst_n)
		(sfrBus.wr && sfrBus.addr == EIEP_ADDR_MASK_TWO)
		|=> maskTwo == {$past(sfrBus.wdata[EIEP_BIT_MATCH]), $past(sfrBus.wdata[EIEP_BIT_DROPOUT])};
	endproperty
	a_mask_any_page: assert property (p_mask_any_page)
		else $error("enable register write lost on some page");

	property p_global_off;
		@(posedge clk) disable iff (!rst_n)
		!globalIrqEnable |=> !irqHigh && !irqLow;
	endproperty
	a_global_off: assert property (p_global_off)
		else $error("interrupt presented with global enable cleared");

	property p_high_first;
		@(posedge clk) disable iff (!rst_n)
		irqLow |-> !irqHigh && $past(highVec) == '0;
	endproperty
	a_high_first: assert property (p_high_first)
		else $error("low request presented while high pending");

endmodule : eiep_ctrl

/* dv/eiep_src_model.sv */
// eiep_src_model: peripheral request flags, served by a core that clears what it sees
`timescale 1ns/100ps
module eiep_src_model
	import eiep_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       irqHigh,
	input  wire logic       irqLow,
	input  wire logic [3:0] irqSource,
	input  wire logic       holdOn,
	input  wire logic [9:0] holdPat,  // {groupOne, match, dropout}
	output eiep_req_t       srcReq
);
	logic [9:0] flags;
	logic [9:0] pat;
	logic       hold;
	int         pick;
	int         svc;

	// flags rise at random, or follow a held pattern; a served source is cleared
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags = 10'h000;
		end else begin
			pick = $urandom_range(15);
			hold = holdOn;   // taken at the edge, so the bench never races it
			pat = holdPat;
			#1;
			svc = int'(irqSource);
			if (hold)
				flags = pat;
			else if ((irqHigh || irqLow) && pick < 4)
				flags[svc < 8 ? svc + 2 : 9 - svc] = 1'b0; // vector order: groupOne, match, dropout
			else if (pick < 10)
				flags[pick] = 1'b1;
		end
	end
	assign srcReq = flags;
endmodule : eiep_src_model

/* dv/extended_irq_enable_priority_test.sv */
// extended_irq_enable_priority_test: bench of eiep_ctrl against a cycle model
`timescale 1ns/100ps
module extended_irq_enable_priority_test
	import eiep_pkg::*;
;
	logic       clk, rst_n, glob, monOn, rdNow, holdOn;
	eiep_sfr_t  sfrBus;
	eiep_req_t  srcReq;
	logic [7:0] grpEn, sfrRdata, prioOne, rdExp, rdHeld;
	logic       sfrAck, irqHigh, irqLow;
	logic [3:0] irqSource;
	logic [1:0] groupTwoEnable, maskTwo, prioTwo;
	logic [9:0] req, en, pri, holdPat;
	// held request patterns {groupOne, match, dropout}: match, dropout, lin+counter, lin
	logic [9:0] pats[4] = '{10'h002, 10'h001, 10'h220, 10'h200};
	int         error_cnt, total_checks, cycles, dummy, hi, lo, hit;
	logic [7:0] addrs[4] = '{8'he7, 8'hf6, 8'hf7, 8'he6};
	logic [7:0] pages[3] = '{8'h00, 8'h0f, 8'h05};

	eiep_ctrl u_eiep_ctrl (.clk(clk), .rst_n(rst_n), .sfrBus(sfrBus), .srcReq(srcReq),
		.groupOneEnable(grpEn), .globalIrqEnable(glob), .sfrRdata(sfrRdata), .sfrAck(sfrAck),
		.irqHigh(irqHigh), .irqLow(irqLow), .irqSource(irqSource),
		.groupTwoEnable(groupTwoEnable));
	eiep_src_model u_eiep_src_model (.clk(clk), .rst_n(rst_n), .irqHigh(irqHigh),
		.irqLow(irqLow), .irqSource(irqSource), .holdOn(holdOn), .holdPat(holdPat),
		.srcReq(srcReq));

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// one bus cycle, driven just after the edge and held for the whole cycle
	task automatic busOp(input logic w, input logic r, input logic [7:0] a,
		input logic [7:0] p, input logic [7:0] d);
		@(posedge clk);
		#1 sfrBus = '{addr: a, page: p, wr: w, rd: r, wdata: d};
	endtask : busOp

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// hang guard: the whole run needs under fifteen hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			error_cnt++;
			complete_run();
		end
	end

	// cycle model: expectation from what this edge takes, compared once outputs settle
	always @(posedge clk) begin
		req = {srcReq.dropout, srcReq.match, srcReq.groupOne};
		en = {maskTwo[0], maskTwo[1], grpEn};
		pri = {prioTwo[0], prioTwo[1], prioOne};
		hi = -1;
		lo = -1;
		for (int i = 9; i >= 0; i--) if (glob && req[i] && en[i]) begin
			if (pri[i]) hi = i;
			else lo = i;
		end
		hit = sfrBus.addr == 8'he7 || ((sfrBus.addr == 8'hf6 || sfrBus.addr == 8'hf7)
			&& (sfrBus.page == 8'h00 || sfrBus.page == 8'h0f));
		rdExp = !hit ? 8'h00 : sfrBus.addr == 8'hf6 ? prioOne : sfrBus.addr == 8'he7
			? {5'h00, maskTwo[1], 1'b0, maskTwo[0]} : {5'h00, prioTwo[1], 1'b0, prioTwo[0]};
		rdNow = sfrBus.rd;
		if (rst_n && sfrBus.rd) rdHeld = rdExp;
		if (!rst_n) begin
			{prioOne, maskTwo, prioTwo} = '0;
			rdHeld = 8'h00;
		end else if (sfrBus.wr && hit) begin
			if (sfrBus.addr == 8'hf6) prioOne = sfrBus.wdata;
			else if (sfrBus.addr == 8'he7) maskTwo = {sfrBus.wdata[2], sfrBus.wdata[0]};
			else prioTwo = {sfrBus.wdata[2], sfrBus.wdata[0]};
		end
		#2;
		if (monOn) begin
			chk("irqHigh", irqHigh, hi >= 0);
			chk("irqLow", irqLow, hi < 0 && lo >= 0);
			chk("irqSource", irqSource, hi >= 0 ? hi : lo >= 0 ? lo : 0);
			chk("groupTwoEnable", groupTwoEnable, maskTwo);
			chk("sfrAck", sfrAck, rdNow && hit);
			chk("sfrRdata", sfrRdata, rdHeld);
		end
	end

	initial begin
		rst_n = 1'b0;
		monOn = 1'b0;
		glob = 1'b0;
		grpEn = 8'h00;
		sfrBus = '0;
		holdOn = 1'b0;
		holdPat = 10'h000;
		error_cnt = 0;
		total_checks = 0;
		cycles = 0;
		dummy = $urandom(32'hc79fc1a4);
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge clk);
		#1 monOn = 1'b1;
		// registers read back their reset values
		foreach (addrs[i]) busOp(1'b0, 1'b1, addrs[i], 8'h00, 8'h00);
		$display("test reset_values done");
		// every address on every page: write, write with read, read
		foreach (addrs[i]) foreach (pages[j]) begin
			busOp(1'b1, 1'b0, addrs[i], pages[j], $urandom);
			busOp(1'b1, 1'b1, addrs[i], pages[j], $urandom);
			busOp(1'b0, 1'b1, addrs[i], pages[j], 8'h00);
		end
		$display("test decode done");
		// all enabled, global off then on
		busOp(1'b1, 1'b0, 8'he7, 8'h05, 8'hff);
		grpEn = 8'hff;
		repeat (40) busOp(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
		glob = 1'b1;
		repeat (40) busOp(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
		$display("test global_enable done");
		// one request pattern held still against every second-group mask and priority pairing, group one enables fixed at lin+counter
		holdOn = 1'b1;
		grpEn = 8'h88;
		foreach (pats[p]) for (int k = 0; k < 16; k++) begin
			holdPat = pats[p];
			busOp(1'b1, 1'b0, 8'he7, 8'h05, {5'h00, k[0], 1'b0, k[1]});
			busOp(1'b1, 1'b0, 8'hf7, 8'h0f, {5'h00, k[2], 1'b0, k[3]});
			busOp(1'b1, 1'b0, 8'hf6, 8'h00, {k[2], 3'h0, k[3], 3'h0});
			repeat (2) busOp(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
		end
		holdOn = 1'b0;
		$display("test single_source done");
		// random masks, priorities, global enable and bus traffic
		repeat (600) begin
			dummy = $urandom_range(7);
			busOp(dummy == 0, dummy == 1, addrs[$urandom_range(3)], pages[$urandom_range(2)],
				$urandom);
			if (dummy == 2) grpEn = $urandom;
			if (dummy == 3) glob = $urandom_range(9) > 1;
		end
		$display("test random_traffic done");
		// reset in mid-run clears every implemented bit
		repeat (2) @(posedge clk);
		#1 monOn = 1'b0;
		rst_n = 1'b0;
		sfrBus = '0;
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge clk);
		#1 monOn = 1'b1;
		foreach (addrs[i]) busOp(1'b0, 1'b1, addrs[i], 8'h0f, 8'h00);
		repeat (2) busOp(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
		$display("test mid_reset done");
		complete_run();
	end
endmodule : extended_irq_enable_priority_test
